/* File: design/lagu_top.sv */
// load unit: decode, address generation, base update, result placing
// assumes: same-clock issue logic, register file and data memory;
// memory read data is valid two cycles after the request cycle
//
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/1ns
`include "lagu_defines.svh"

module lagu_top
    import lagu_pkg::*;
(
    // clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // apb slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [`LAGU_AW-1:0]  paddr,
    input  wire logic [31:0]          pwdata,
    output logic                      pready,
    output logic      [31:0]          prdata,
    output logic                      pslverr,
    // instruction issue
    input  wire logic                 instr_valid,
    input  wire logic [31:0]          instr_word,
    input  wire logic                 cond_pass,
    // register file read
    output logic                      rf_rd_side,
    output logic      [4:0]           base_pointer_idx,
    output logic      [4:0]           index_reg_idx,
    input  wire logic [31:0]          base_pointer_reg,
    input  wire logic [31:0]          index_reg,
    // data memory
    output logic                      mem_req,
    output logic      [31:0]          mem_addr,
    output logic      [1:0]           mem_size,
    input  wire logic [31:0]          mem_rdata,
    // base write back
    output logic                      base_we,
    output logic                      base_side,
    output logic      [4:0]           base_idx,
    output logic      [31:0]          base_data,
    // destination write back
    output logic                      dst_we,
    output logic                      dst_side,
    output logic      [4:0]           dst_idx,
    output logic      [31:0]          dst_data
);

    lagu_state_t   q;
    lagu_state_t   d;

    logic [3:0]    mode;
    logic [2:0]    load_type_field;
    logic [4:0]    short_unsigned_imm;
    logic          is_load;
    logic          fire;
    logic [1:0]    shift;
    logic [31:0]   offs;
    logic          circ;
    logic [1:0]    am_pair;
    logic [31:0]   mask;
    logic [31:0]   addr_new;
    logic [31:0]   shifted;
    logic [15:0]   status_lo;
    logic [31:0]   amctrl_val;
    lagu_stage_t   st_new;

    // ****************************************************************
    // decode
    // ****************************************************************
    assign mode               = instr_word[`LAGU_F_MODE_MSB:
                                           `LAGU_F_MODE_LSB];
    assign load_type_field    = instr_word[`LAGU_F_KIND_MSB:
                                           `LAGU_F_KIND_LSB];
    assign short_unsigned_imm = instr_word[`LAGU_F_OFF_MSB:
                                           `LAGU_F_OFF_LSB];

    always_comb begin
        is_load = 1'b0;
        shift   = `LAGU_SH_BYTE;
        if (instr_word[`LAGU_F_FMT_MSB:`LAGU_F_FMT_LSB]
            == `LAGU_FMT_LOAD) begin
            case (load_type_field)
                `LAGU_LD_SB, `LAGU_LD_UB: begin
                    is_load = 1'b1;
                    shift   = `LAGU_SH_BYTE;
                end
                `LAGU_LD_SH, `LAGU_LD_UH: begin
                    is_load = 1'b1;
                    shift   = `LAGU_SH_HALF;
                end
                `LAGU_LD_W: begin
                    is_load = 1'b1;
                    shift   = `LAGU_SH_WORD;
                end
                default: begin
                    is_load = 1'b0;
                    shift   = `LAGU_SH_BYTE;
                end
            endcase
        end
    end

    assign fire = instr_valid & is_load & cond_pass;

    // side bit picks file for base and index
    assign rf_rd_side       = instr_word[`LAGU_F_Y];
    assign base_pointer_idx = instr_word[`LAGU_F_BASE_MSB:
                                         `LAGU_F_BASE_LSB];
    assign index_reg_idx    = short_unsigned_imm;

    assign offs = mode[`LAGU_M_REGOFF] ? index_reg
                                       : {27'h0, short_unsigned_imm};

    always_comb begin
        am_pair = q.am_mode[{rf_rd_side, base_pointer_idx[1:0], 1'b0}
                            +: 2];
        circ    = (base_pointer_idx >= `LAGU_CIRC_FIRST) &&
                  (base_pointer_idx <= `LAGU_CIRC_LAST) &&
                  (am_pair == `LAGU_AM_CIRC);
        mask    = ~(32'hffffffff << ({1'b0, q.am_blk} + 6'd1));
    end

    lagu_addr_calc #(
        .W        (32)
    ) u_calc (
        .base     (base_pointer_reg),
        .offs     (offs),
        .shift    (shift),
        .add      (mode[`LAGU_M_ADD]),
        .circ     (circ),
        .mask     (mask),
        .addr_new (addr_new)
    );

    // ****************************************************************
    // apb
    // ****************************************************************
    assign pready     = 1'b1;
    assign prdata     = q.prdata;
    assign pslverr    = q.pslverr;
    assign status_lo  = {13'h0, q.pipe[2].vld, q.pipe[1].vld,
                         q.pipe[0].vld};
    assign amctrl_val = {11'h0, q.am_blk, q.am_mode};

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        d      = q;
        st_new = '0;
        // apb read data prepared in setup phase
        if (psel && !penable) begin
            d.pslverr = 1'b0;
            if (paddr == `LAGU_OFF_AMCTRL) begin
                d.prdata = amctrl_val;
            end else if (paddr == `LAGU_OFF_STATUS) begin
                d.prdata = {q.load_cnt, status_lo};
            end else begin
                d.prdata  = 32'h0;
                d.pslverr = 1'b1;
            end
        end
        if (psel && penable && pwrite &&
            paddr == `LAGU_OFF_AMCTRL) begin
            d.am_mode = pwdata[15:0];
            d.am_blk  = pwdata[`LAGU_BLK_MSB:`LAGU_BLK_LSB];
        end
        // post-modify modes (modify and post bits both set) access the old base
        d.mem_req  = fire;
        d.mem_size = shift;
        if (fire) begin
            d.mem_addr = (mode[`LAGU_M_MODIFY] && mode[`LAGU_M_POST])
                         ? base_pointer_reg : addr_new;
            d.load_cnt = q.load_cnt + 16'h1;
        end
        // modify bit updates base, visible next cycle
        d.base_we = fire & mode[`LAGU_M_MODIFY];
        if (fire && mode[`LAGU_M_MODIFY]) begin
            d.base_side = rf_rd_side;
            d.base_idx  = base_pointer_idx;
            d.base_data = addr_new;
        end
        st_new.vld  = fire;
        st_new.kind = lagu_ld_kind_t'(load_type_field);
        st_new.side = instr_word[`LAGU_F_S];
        st_new.idx  = instr_word[`LAGU_F_DST_MSB:`LAGU_F_DST_LSB];
        st_new.lsb  = d.mem_addr[1:0];
        d.pipe[0] = fire ? st_new : '0;
        d.pipe[1] = q.pipe[0];
        d.pipe[2] = q.pipe[1];
        d.dst_we  = q.pipe[2].vld;
        shifted   = mem_rdata >> {q.pipe[2].lsb, 3'b000};
        if (q.pipe[2].vld) begin
            d.dst_side = q.pipe[2].side;
            d.dst_idx  = q.pipe[2].idx;
            case (q.pipe[2].kind)
                load_signed_byte: begin
                    d.dst_data = {{24{shifted[7]}}, shifted[7:0]};
                end
                load_signed_half: begin
                    d.dst_data = {{16{shifted[15]}}, shifted[15:0]};
                end
                load_unsigned_byte: begin
                    d.dst_data = {24'h0, shifted[7:0]};
                end
                load_unsigned_half: begin
                    d.dst_data = {16'h0, shifted[15:0]};
                end
                default: begin
                    d.dst_data = mem_rdata;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q         <= '0;
            q.am_mode <= `LAGU_AM_RST;
            q.am_blk  <= `LAGU_BLK_RST;
        end else begin
            q <= d;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign mem_req   = q.mem_req;
    assign mem_addr  = q.mem_addr;
    assign mem_size  = q.mem_size;
    assign base_we   = q.base_we;
    assign base_side = q.base_side;
    assign base_idx  = q.base_idx;
    assign base_data = q.base_data;
    assign dst_we    = q.dst_we;
    assign dst_side  = q.dst_side;
    assign dst_idx   = q.dst_idx;
    assign dst_data  = q.dst_data;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic          post_m;
    logic [31:0]   chk_pos;
    assign post_m  = mode[`LAGU_M_MODIFY] & mode[`LAGU_M_POST];
    assign chk_pos = base_pointer_reg +
                     ({27'h0, short_unsigned_imm} << shift);

    property p_side;
        fire && mode[`LAGU_M_MODIFY] |=>
            base_we && base_side == $past(instr_word[`LAGU_F_Y]);
    endproperty
    a_side: assert property (p_side)
        else $error("base side mismatch");

    property p_scale;
        fire && mode == 4'b0001 && !circ |=> mem_addr == $past(chk_pos);
    endproperty
    a_scale: assert property (p_scale)
        else $error("scaled offset address wrong");

    property p_post;
        fire && post_m |=> mem_addr == $past(base_pointer_reg);
    endproperty
    a_post: assert property (p_post)
        else $error("post mode address not old base");

    property p_circ;
        fire && circ && mode[`LAGU_M_MODIFY] |=>
            ((base_data ^ $past(base_pointer_reg)) & ~$past(mask)) == 0;
    endproperty
    a_circ: assert property (p_circ)
        else $error("circular update left the block");

    property p_sbyte;
        fire && load_type_field == `LAGU_LD_SB |->
            ##4 dst_we && dst_data[31:8] == {24{dst_data[7]}};
    endproperty
    a_sbyte: assert property (p_sbyte)
        else $error("signed byte not extended");

    property p_ubyte;
        fire && load_type_field == `LAGU_LD_UB |->
            ##4 dst_we && dst_data[31:8] == 24'h0;
    endproperty
    a_ubyte: assert property (p_ubyte)
        else $error("unsigned byte not zero filled");

    property p_word;
        fire && load_type_field == `LAGU_LD_W |->
            ##4 dst_data == $past(mem_rdata);
    endproperty
    a_word: assert property (p_word)
        else $error("word load altered");

    property p_dfile;
        fire |-> ##4 dst_we && dst_side == $past(instr_word[`LAGU_F_S], 4);
    endproperty
    a_dfile: assert property (p_dfile)
        else $error("destination file wrong");

    property p_nop;
        instr_valid && is_load && !cond_pass && !$past(fire, 3) |=>
            !mem_req && !base_we ##3 !dst_we;
    endproperty
    a_nop: assert property (p_nop)
        else $error("false predicate had an effect");

    c_word: cover property (fire && load_type_field == `LAGU_LD_W);
    c_post: cover property (fire && post_m);
    c_circ: cover property (fire && circ && mode[`LAGU_M_MODIFY]);

endmodule

/* File: design/lagu_defines.svh */
// named constants of the load address generator unit
// assumes: included by bare name, before the package and the modules
`ifndef LAGU_DEFINES_SVH
`define LAGU_DEFINES_SVH

// ********************************************************************
// apb map
// ********************************************************************
`define LAGU_AW           12
`define LAGU_OFF_AMCTRL   12'h000
`define LAGU_OFF_STATUS   12'h004
`define LAGU_AM_RST       16'h0000
`define LAGU_BLK_RST      5'h00
`define LAGU_BLK_LSB      16
`define LAGU_BLK_MSB      20
`define LAGU_CNT_LSB      16

// ********************************************************************
// instruction fields
// ********************************************************************
`define LAGU_F_DST_MSB    27
`define LAGU_F_DST_LSB    23
`define LAGU_F_BASE_MSB   22
`define LAGU_F_BASE_LSB   18
`define LAGU_F_OFF_MSB    17
`define LAGU_F_OFF_LSB    13
`define LAGU_F_MODE_MSB   12
`define LAGU_F_MODE_LSB   9
`define LAGU_F_Y          7
`define LAGU_F_KIND_MSB   6
`define LAGU_F_KIND_LSB   4
`define LAGU_F_FMT_MSB    3
`define LAGU_F_FMT_LSB    2
`define LAGU_F_S          1
`define LAGU_FMT_LOAD     2'b01

// mode field bits
`define LAGU_M_MODIFY     3
`define LAGU_M_REGOFF     2
`define LAGU_M_POST       1
`define LAGU_M_ADD        0

// load type encodings
`define LAGU_LD_SB        3'b010
`define LAGU_LD_UB        3'b001
`define LAGU_LD_SH        3'b100
`define LAGU_LD_UH        3'b000
`define LAGU_LD_W         3'b110

// access size and offset shift
`define LAGU_SH_BYTE      2'd0
`define LAGU_SH_HALF      2'd1
`define LAGU_SH_WORD      2'd2

// circular-capable base registers and mode code
`define LAGU_CIRC_FIRST   5'd4
`define LAGU_CIRC_LAST    5'd7
`define LAGU_AM_CIRC      2'b01

// pipeline depth: dst written after four delay slots
`define LAGU_PIPE_N       3
`endif

/* File: design/lagu_pkg.sv */
// types of the load address generator unit
// assumes: lagu_defines.svh on the include path
`include "lagu_defines.svh"

package lagu_pkg;

    typedef enum logic [2:0] {
        load_unsigned_half = `LAGU_LD_UH,
        load_unsigned_byte = `LAGU_LD_UB,
        load_signed_byte   = `LAGU_LD_SB,
        load_signed_half   = `LAGU_LD_SH,
        load_full_word     = `LAGU_LD_W
    } lagu_ld_kind_t;

    typedef struct packed {
        logic          vld;
        lagu_ld_kind_t kind;
        logic          side;
        logic [4:0]    idx;
        logic [1:0]    lsb;
    } lagu_stage_t;

    typedef struct packed {
        logic [15:0]                   am_mode;
        logic [4:0]                    am_blk;
        logic [31:0]                   prdata;
        logic                          pslverr;
        logic [15:0]                   load_cnt;
        logic                          mem_req;
        logic [31:0]                   mem_addr;
        logic [1:0]                    mem_size;
        logic                          base_we;
        logic                          base_side;
        logic [4:0]                    base_idx;
        logic [31:0]                   base_data;
        lagu_stage_t [`LAGU_PIPE_N-1:0] pipe;
        logic                          dst_we;
        logic                          dst_side;
        logic [4:0]                    dst_idx;
        logic [31:0]                   dst_data;
    } lagu_state_t;

endpackage

/* File: design/lagu_addr_calc.sv */
// offset scaling and linear or circular address arithmetic
// assumes: purely combinational, driven from the unit's decode
`timescale 1ns/1ns

module lagu_addr_calc #(
    parameter int W = 32
) (
    // operands
    input  wire logic [W-1:0] base,
    input  wire logic [W-1:0] offs,
    input  wire logic [1:0]   shift,
    input  wire logic         add,
    // circular control
    input  wire logic         circ,
    input  wire logic [W-1:0] mask,
    // result
    output logic      [W-1:0] addr_new
);

    logic [W-1:0] scaled;
    logic [W-1:0] lin;

    always_comb begin
        scaled = offs << shift;
        lin    = add ? base + scaled : base - scaled;
        if (circ) begin
            addr_new = (base & ~mask) | (lin & mask);
        end else begin
            addr_new = lin;
        end
    end

endmodule

/* File: test/lagu_mem_model.sv */
// data memory model answering load requests of the unit
// assumes: one clock with the unit; read data due two cycles after request
`timescale 1ns/1ns

module lagu_mem_model (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // load request and answer
    input  wire logic        mem_req,
    input  wire logic [31:0] mem_addr,
    output logic      [31:0] mem_rdata
);
    logic        hit_q;
    logic [31:0] addr_q;

    // content of an aligned word, a fixed scramble of its address
    function automatic logic [31:0] word_at(input logic [31:0] a);
        return (a * 32'h9e37_79b1) ^ 32'h5a3c_c3a5;
    endfunction

    // ****************************************
    // answer, garbage outside the valid cycle
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hit_q     <= 1'b0;
            addr_q    <= 32'h0;
            mem_rdata <= 32'h0;
        end else begin
            hit_q  <= mem_req;
            addr_q <= mem_addr;
            if (hit_q) begin
                mem_rdata <= word_at({addr_q[31:2], 2'b00});
            end else begin
                mem_rdata <= ~mem_rdata;
            end
        end
    end
endmodule

/* File: test/load_addr_gen_unit_tb.sv */
// self-checking bench of the load unit with register file and memory
// assumes: lagu_pkg compiled first, lagu_defines.svh on the include path
`timescale 1ns/1ns
`include "lagu_defines.svh"

module load_addr_gen_unit_tb;
    import lagu_pkg::*;

    logic        pclk, presetn, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, instr_word, mem_rdata, mem_addr;
    logic [31:0] base_data, dst_data;
    logic        pready, pslverr, instr_valid, cond_pass, rf_rd_side;
    logic [4:0]  base_pointer_idx, index_reg_idx, base_idx, dst_idx;
    logic        mem_req, base_we, base_side, dst_we, dst_side;
    logic [1:0]  mem_size;
    logic [31:0] rf [2][32];
    int          err_total, num_checks, n_loads;
    logic [3:0]  modes [12] = '{4'h1, 4'h0, 4'h9, 4'h8, 4'hb, 4'ha,
                                4'h5, 4'h4, 4'hd, 4'hc, 4'hf, 4'he};
    logic [2:0]  kinds [5] = '{3'b010, 3'b001, 3'b100, 3'b000, 3'b110};

    lagu_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .instr_valid(instr_valid), .instr_word(instr_word),
        .cond_pass(cond_pass), .rf_rd_side(rf_rd_side),
        .base_pointer_idx(base_pointer_idx), .index_reg_idx(index_reg_idx),
        .base_pointer_reg(rf[rf_rd_side][base_pointer_idx]),
        .index_reg(rf[rf_rd_side][index_reg_idx]), .mem_req(mem_req),
        .mem_addr(mem_addr), .mem_size(mem_size), .mem_rdata(mem_rdata),
        .base_we(base_we), .base_side(base_side), .base_idx(base_idx),
        .base_data(base_data), .dst_we(dst_we), .dst_side(dst_side),
        .dst_idx(dst_idx), .dst_data(dst_data));

    lagu_mem_model i_mem (.pclk(pclk), .presetn(presetn),
        .mem_req(mem_req), .mem_addr(mem_addr), .mem_rdata(mem_rdata));

    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic final_report;
        if (err_total == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic er);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd      = prdata;
        er      = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // expected destination value from memory word and load type
    function automatic logic [31:0] place(input logic [2:0] k,
                                          input logic [31:0] a);
        logic [31:0] w;
        logic [7:0]  b;
        logic [15:0] h;
        w = i_mem.word_at({a[31:2], 2'b00});
        b = w[8*a[1:0] +: 8];
        h = w[16*a[1] +: 16];
        case (k)
            `LAGU_LD_SB: return {{24{b[7]}}, b};
            `LAGU_LD_UB: return {24'h0, b};
            `LAGU_LD_SH: return {{16{h[15]}}, h};
            `LAGU_LD_UH: return {16'h0, h};
            default:     return w;
        endcase
    endfunction

    // one load; cmask is the circular wrap mask, zero for linear
    task automatic do_load(input logic [2:0] k, input logic [3:0] m,
        input logic y, input logic s, input logic [4:0] bi,
        input logic [4:0] oi, input logic [4:0] di, input logic [31:0] bv,
        input logic [31:0] ov, input logic [31:0] cmask);
        logic [31:0] sc, lin, nw, acc;
        logic [1:0]  sh;
        sh  = (k == `LAGU_LD_W) ? 2'd2 : (k[2] || k == 3'b000) ? 2'd1 : 2'd0;
        sc  = (m[2] ? ov : {27'h0, ov[4:0]}) << sh;
        lin = m[0] ? bv + sc : bv - sc;
        nw  = (cmask == 32'h0) ? lin : ((bv & ~cmask) | (lin & cmask));
        acc = (m[3] && m[1]) ? bv : nw;
        @(posedge pclk);
        rf[y][bi]   <= bv;
        rf[y][oi]   <= ov;
        // program keeps reserved bit zero
        instr_word  <= {4'h0, di, bi, (m[2] ? oi : ov[4:0]), m, 1'b0, y, k,
                        `LAGU_FMT_LOAD, s, 1'b0};
        instr_valid <= 1'b1;
        cond_pass   <= 1'b1;
        @(posedge pclk);
        instr_valid <= 1'b0;
        #1;
        chk(mem_req, 1);
        chk(mem_addr, acc);
        chk(mem_size, sh);
        chk(base_we, m[3]);
        if (m[3]) begin
            chk(base_data, nw);
            chk({base_side, base_idx}, {y, bi});
        end
        repeat (3) @(posedge pclk);
        #1;
        chk(dst_we, 1);
        chk(dst_data, place(k, acc));
        chk({dst_side, dst_idx}, {s, di});
        n_loads++;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_regs;
        logic [31:0] d;
        logic        e;
        apb(0, `LAGU_OFF_AMCTRL, 0, d, e);
        chk(d, 32'h0);
        apb(1, `LAGU_OFF_AMCTRL, 32'h001f_a5c3, d, e);
        apb(0, `LAGU_OFF_AMCTRL, 0, d, e);
        chk(d, 32'h001f_a5c3);
        apb(0, 12'h0f0, 0, d, e);
        chk(e, 1);
        apb(1, `LAGU_OFF_AMCTRL, 0, d, e);
    endtask

    task automatic t_kinds;
        for (int k = 0; k < 5; k++) begin
            for (int l = 0; l < 4; l++) begin
                do_load(kinds[k], 4'h1, l[0], ~l[0], 5'd3, 5'd0, 5'(l),
                    32'h1000 + (kinds[k] == 3'b110 ? 0 :
                    (kinds[k][2] || kinds[k] == 0) ? 2 * l[0] : l),
                    32'd31, 32'h0);
            end
        end
    endtask

    task automatic t_modes;
        for (int i = 0; i < 12; i++) begin
            do_load(3'b110, modes[i], i[0], ~i[0], 5'd9, 5'd12, 5'(i),
                32'h400, 32'd3, 32'h0);
        end
    endtask

    task automatic t_circ;
        logic [31:0] d;
        logic        e;
        apb(1, `LAGU_OFF_AMCTRL, 32'h0003_0001, d, e);
        do_load(3'b110, 4'h9, 0, 0, 5'd4, 5'd1, 5'd2, 32'h10c, 2,
            32'hf);
        do_load(3'b110, 4'h9, 0, 0, 5'd0, 5'd1, 5'd2, 32'h10c, 2, 0);
        do_load(3'b110, 4'h9, 1, 0, 5'd4, 5'd1, 5'd2, 32'h10c, 2, 0);
        apb(1, `LAGU_OFF_AMCTRL, 0, d, e);
        apb(0, `LAGU_OFF_STATUS, 0, d, e);
        chk(d[31:16], n_loads);
    endtask

    task automatic t_refuse(input logic [31:0] w, input logic c);
        @(posedge pclk);
        instr_word  <= w;
        cond_pass   <= c;
        instr_valid <= 1'b1;
        @(posedge pclk);
        instr_valid <= 1'b0;
        repeat (6) begin
            #1;
            chk({mem_req, base_we, dst_we}, 0);
            @(posedge pclk);
        end
    endtask

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        final_report;
    end

    initial begin
        presetn = 0;
        {psel, penable, pwrite, instr_valid, cond_pass} = '0;
        paddr = '0;
        pwdata = '0;
        instr_word = '0;
        foreach (rf[i, j]) rf[i][j] = '0;
        err_total = 0;
        num_checks = 0;
        n_loads = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_kinds;
        t_modes;
        t_circ;
        t_refuse({4'h0, 5'd1, 5'd2, 5'd3, 4'h9, 2'b0, 3'b110, 2'b01, 2'b0}, 0);
        t_refuse({4'h0, 5'd1, 5'd2, 5'd3, 4'h9, 2'b0, 3'b011, 2'b01, 2'b0}, 1);
        final_report;
    end
endmodule
